//--- map_ram.v
// Simple dual-port store for 32-bit DMA mapping entries
`timescale 1ns/100ps
module map_ram #(
    parameter DW = 30,
    parameter AW = 4,
    parameter DEPTH = 16
) (
    input wire clock_i,
    input wire wr_en_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [DW-1:0] wr_data_i,
    input wire rd_en_i,
    input wire [AW-1:0] rd_addr_i,
    output reg [DW-1:0] rd_data_o
);

reg [DW-1:0] mem [0:DEPTH-1];

always @(posedge clock_i)
begin
    if (wr_en_i)
    begin
        mem[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i)
    begin
        rd_data_o <= mem[rd_addr_i];
    end
end

endmodule // map_ram

//--- pcix_bridge_bus.v
// Bus-side logic of a 64-bit PCI-X host bridge with two slots
//
// Behaviour
// - Bus lock is ignored; no locked sequences.
// - Both snoop inputs are ignored.
// - Dual-cycle 64-bit DMA addresses are accepted.
// - PIO master cycles use 32-bit addresses only.
// - 64-bit data path; wide requests acknowledged.
// - 133 MHz PCI-X only with one card, other slot disabled.
// - Two PCI-X cards run at 100 or 66 MHz.
// - Two conventional cards run at 66 or 33 MHz.
// - Mixed cards take the slowest card's mode and speed.
// - PIO memory windows lie below 0x400_0000.
// - High bits of 64-bit addresses select prefetch and byte swap.
// - DMA addresses become 50-bit physical, maybe remote.
// - 32-bit cards map through mapping registers.
// - Mapping fails when no register is free.
// - 64-bit DMA addresses map directly.
// - Real-time and low-priority groups, each round-robin.
// - Real-time requests win over low-priority ones.
// - Per slot, lines A and C join; B and D join.
// - Slot n A/C drives input n mod 8; B/D drives (n+4) mod 8.
`timescale 1ns/100ps
`include "pcix_bridge_defs.vh"
module pcix_bridge_bus #(
    parameter SLOTS = 2,
    parameter RT_MASK = 2'b01,
    parameter MAP_ENTRIES = 16,
    parameter MAP_AW = 4,
    parameter LOCAL_NODE = 12'h000
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire pci_clk_i,
    input wire lock_b_i,
    input wire sbo_b_i,
    input wire sdone_i,
    input wire frame_b_i,
    input wire req64_b_i,
    input wire [3:0] cbe_i,
    input wire [63:0] ad_i,
    input wire [SLOTS-1:0] req_b_i,
    input wire [4*SLOTS-1:0] int_b_i,
    input wire [SLOTS-1:0] slot_present_i,
    input wire [SLOTS-1:0] slot_pcix_i,
    input wire [2*SLOTS-1:0] slot_speed_i,
    input wire pio_req_i,
    input wire pio_write_i,
    input wire [31:0] pio_addr_i,
    input wire map_req_i,
    input wire [`PHYS_PAGE_WIDTH-1:0] map_page_i,
    input wire [1:0] map_ctl_i,
    input wire map_free_i,
    input wire [MAP_AW-1:0] map_free_index_i,
    output reg [SLOTS-1:0] gnt_b_o,
    output reg [7:0] bridge_irq_o,
    output reg bus_pcix_o,
    output reg [1:0] bus_speed_o,
    output reg [SLOTS-1:0] slot_enable_o,
    output reg ack64_b_o,
    output reg ack64_oe_o,
    output reg mst_frame_b_o,
    output reg mst_oe_o,
    output reg [31:0] mst_ad_o,
    output reg [3:0] mst_cbe_o,
    output wire pio_busy_o,
    output reg pio_done_o,
    output reg pio_err_o,
    output reg map_ack_o,
    output reg map_fail_o,
    output reg [MAP_AW-1:0] map_index_o,
    output reg dma_valid_o,
    output reg dma_miss_o,
    output reg [`PHYS_WIDTH-1:0] dma_phys_o,
    output reg dma_remote_o,
    output reg dma_prefetch_o,
    output reg dma_swap_o
);

localparam SW = 1 + 1 + 1 + 4 + 64 + SLOTS + 4 * SLOTS + SLOTS + SLOTS + 2 * SLOTS;
localparam T_IDLE = 2'h0;
localparam T_HIGH = 2'h1;
localparam T_LOOK = 2'h2;
localparam T_BUSY = 2'h3;
localparam P_IDLE = 2'h0;
localparam P_WAIT = 2'h1;
localparam P_ADDR = 2'h2;
localparam NW = `PHYS_WIDTH - `NODE_LSB;

// Lock and snoop pins are deliberately never read
wire [SW-1:0] raw_in = {pci_clk_i, frame_b_i, req64_b_i, cbe_i, ad_i, req_b_i,
    int_b_i, slot_present_i, slot_pcix_i, slot_speed_i};
reg [SW-1:0] sync1;
reg [SW-1:0] sync2;
reg pclk_d;

always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        sync1 <= {{(SW-4*SLOTS){1'b1}}, {(4*SLOTS){1'b0}}};
        sync2 <= {{(SW-4*SLOTS){1'b1}}, {(4*SLOTS){1'b0}}};
        pclk_d <= 1'b1;
    end
    else
    begin
        sync1 <= raw_in;
        sync2 <= sync1;
        pclk_d <= sync2[SW-1];
    end
end

wire pclk_s = sync2[SW-1];
wire frame_s = sync2[SW-2];
wire req64_s = sync2[SW-3];
wire [3:0] cbe_s = sync2[SW-4:SW-7];
wire [63:0] ad_s = sync2[SW-8:SW-71];
wire [SLOTS-1:0] req_s = sync2[SW-72:SW-71-SLOTS];
wire [4*SLOTS-1:0] int_s = sync2[SW-72-SLOTS:SW-71-5*SLOTS];
wire [SLOTS-1:0] pres_s = sync2[4*SLOTS-1:3*SLOTS];
wire [SLOTS-1:0] pcix_s = sync2[3*SLOTS-1:2*SLOTS];
wire [2*SLOTS-1:0] spd_s = sync2[2*SLOTS-1:0];
wire pci_rise = pclk_s & ~pclk_d;

// Bus speed and mode from the cards that are present
reg next_pcix;
reg [1:0] next_speed;
reg [1:0] cap;
reg any_card;
reg multi;
integer s;

always @*
begin
    next_pcix = 1'b1;
    next_speed = `SPEED_133;
    any_card = 1'b0;
    multi = 1'b0;
    cap = `SPEED_33;
    for (s = 0; s < SLOTS; s = s + 1)
    begin
        if (pres_s[s])
        begin
            multi = multi | any_card;
            any_card = 1'b1;
            cap = spd_s[2*s +: 2];
            if (!pcix_s[s] && cap > `SPEED_66)
            begin
                cap = `SPEED_66;
            end
            if (cap < next_speed)
            begin
                next_speed = cap;
            end
            if (!pcix_s[s])
            begin
                next_pcix = 1'b0;
            end
        end
    end
    if (!next_pcix && next_speed > `SPEED_66)
    begin
        next_speed = `SPEED_66;
    end
    if (multi && next_speed == `SPEED_133)
    begin
        next_speed = `SPEED_100;
    end
    if (!any_card)
    begin
        next_pcix = 1'b0;
        next_speed = `SPEED_33;
    end
end

always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        bus_pcix_o <= 1'b0;
        bus_speed_o <= `SPEED_33;
        slot_enable_o <= {SLOTS{1'b0}};
    end
    else
    begin
        bus_pcix_o <= next_pcix;
        bus_speed_o <= next_speed;
        slot_enable_o <= pres_s;
    end
end

// Two-group arbiter, regranted at bus edges while idle
wire [SLOTS-1:0] req_act = ~req_s;
wire [SLOTS-1:0] rt_gnt;
wire [SLOTS-1:0] lp_gnt;
wire rt_any;
wire lp_any;
wire arb_step = pci_rise & frame_s;

rr_group #(.N(SLOTS), .PW(1)) rt_arb (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .req_i(req_act & RT_MASK),
    .advance_i(arb_step),
    .grant_o(rt_gnt),
    .any_o(rt_any)
);

rr_group #(.N(SLOTS), .PW(1)) lp_arb (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .req_i(req_act & ~RT_MASK),
    .advance_i(arb_step & ~rt_any),
    .grant_o(lp_gnt),
    .any_o(lp_any)
);

always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        gnt_b_o <= {SLOTS{1'b1}};
    end
    else if (arb_step)
    begin
        gnt_b_o <= rt_any ? ~rt_gnt : (lp_any ? ~lp_gnt : {SLOTS{1'b1}});
    end
end

// Card interrupt lines folded onto the eight bridge inputs
function irq_for;
    input [4*SLOTS-1:0] act;
    input integer j;
    integer n;
    begin
        irq_for = 1'b0;
        for (n = 0; n < SLOTS; n = n + 1)
        begin
            if (n % 8 == j)
            begin
                irq_for = irq_for | act[4*n] | act[4*n+2];
            end
            if ((n + 4) % 8 == j)
            begin
                irq_for = irq_for | act[4*n+1] | act[4*n+3];
            end
        end
    end
endfunction

genvar j;
generate
    for (j = 0; j < 8; j = j + 1)
    begin : irq_map
        always @(posedge clock_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
            begin
                bridge_irq_o[j] <= 1'b0;
            end
            else
            begin
                bridge_irq_o[j] <= irq_for(~int_s, j);
            end
        end
    end
endgenerate

// Mapping register pool for 32-bit DMA
reg [MAP_ENTRIES-1:0] map_valid;
reg [MAP_AW-1:0] free_idx;
reg free_found;
integer e;

always @*
begin
    free_idx = {MAP_AW{1'b0}};
    free_found = 1'b0;
    for (e = MAP_ENTRIES - 1; e >= 0; e = e - 1)
    begin
        if (!map_valid[e])
        begin
            free_found = 1'b1;
            free_idx = e[MAP_AW-1:0];
        end
    end
end

wire map_wr = map_req_i & free_found;
wire [MAP_AW-1:0] look_idx = ad_s[`DMA32_PAGE_BITS +: MAP_AW];
wire look_in_pool = (ad_s[29:`DMA32_PAGE_BITS] < MAP_ENTRIES);
reg [MAP_AW-1:0] look_idx_q;
wire look_start;
wire [`PHYS_PAGE_WIDTH+1:0] entry;

map_ram #(.DW(`PHYS_PAGE_WIDTH + 2), .AW(MAP_AW), .DEPTH(MAP_ENTRIES)) map_store (
    .clock_i(clock_i),
    .wr_en_i(map_wr),
    .wr_addr_i(free_idx),
    .wr_data_i({map_ctl_i, map_page_i}),
    .rd_en_i(look_start),
    .rd_addr_i(look_idx),
    .rd_data_o(entry)
);

always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        map_valid <= {MAP_ENTRIES{1'b0}};
        map_ack_o <= 1'b0;
        map_fail_o <= 1'b0;
        map_index_o <= {MAP_AW{1'b0}};
    end
    else
    begin
        map_ack_o <= map_wr;
        map_fail_o <= map_req_i & ~free_found;
        if (map_wr)
        begin
            map_index_o <= free_idx;
        end
        if (map_free_i)
        begin
            map_valid[map_free_index_i] <= 1'b0;
        end
        // A new allocation wins over a free of the same entry
        if (map_wr)
        begin
            map_valid[free_idx] <= 1'b1;
        end
    end
end

// Inbound target address decode and translation
reg [1:0] tstate;
reg frame_q;
reg claimed;
reg [31:0] addr_lo;
wire addr_start = pci_rise & ~frame_s & frame_q;
wire is_mem = (cbe_s == `CMD_MEM_READ) || (cbe_s == `CMD_MEM_WRITE);
wire in_win32 = (ad_s[31:30] == `DMA32_WIN_SEL);
assign look_start = (tstate == T_IDLE) & addr_start & is_mem & in_win32 & look_in_pool;
wire [63:0] addr64 = {ad_s[31:0], addr_lo};
wire [`PHYS_WIDTH-1:0] phys32 = {entry[`PHYS_PAGE_WIDTH-1:0], addr_lo[`DMA32_PAGE_BITS-1:0]};

always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        tstate <= T_IDLE;
        frame_q <= 1'b1;
        claimed <= 1'b0;
        addr_lo <= 32'h0000_0000;
        look_idx_q <= {MAP_AW{1'b0}};
        dma_valid_o <= 1'b0;
        dma_miss_o <= 1'b0;
        dma_phys_o <= {`PHYS_WIDTH{1'b0}};
        dma_remote_o <= 1'b0;
        dma_prefetch_o <= 1'b0;
        dma_swap_o <= 1'b0;
        ack64_b_o <= 1'b1;
        ack64_oe_o <= 1'b0;
    end
    else
    begin
        dma_valid_o <= 1'b0;
        dma_miss_o <= 1'b0;
        if (pci_rise)
        begin
            frame_q <= frame_s;
        end
        case (tstate)
            T_IDLE:
            begin
                if (addr_start)
                begin
                    addr_lo <= ad_s[31:0];
                    look_idx_q <= look_idx;
                    if (cbe_s == `CMD_DUAL_ADDR)
                    begin
                        tstate <= T_HIGH;
                    end
                    else if (look_start)
                    begin
                        tstate <= T_LOOK;
                    end
                    else
                    begin
                        dma_miss_o <= is_mem & in_win32;
                        tstate <= T_BUSY;
                    end
                end
            end
            T_HIGH:
            begin
                if (pci_rise)
                begin
                    // Direct map: no pool entry is consumed
                    dma_phys_o <= addr64[`PHYS_WIDTH-1:0];
                    dma_remote_o <= addr64[`PHYS_WIDTH-1:`NODE_LSB] != LOCAL_NODE[NW-1:0];
                    dma_prefetch_o <= addr64[`CTL_PREFETCH_BIT];
                    dma_swap_o <= addr64[`CTL_SWAP_BIT];
                    dma_valid_o <= 1'b1;
                    claimed <= 1'b1;
                    tstate <= T_BUSY;
                end
            end
            T_LOOK:
            begin
                if (map_valid[look_idx_q])
                begin
                    dma_phys_o <= phys32;
                    dma_remote_o <= phys32[`PHYS_WIDTH-1:`NODE_LSB] != LOCAL_NODE[NW-1:0];
                    dma_prefetch_o <= entry[`PHYS_PAGE_WIDTH+1];
                    dma_swap_o <= entry[`PHYS_PAGE_WIDTH];
                    dma_valid_o <= 1'b1;
                    claimed <= 1'b1;
                end
                else
                begin
                    dma_miss_o <= 1'b1;
                end
                tstate <= T_BUSY;
            end
            T_BUSY:
            begin
                if (pci_rise && frame_s)
                begin
                    claimed <= 1'b0;
                    tstate <= T_IDLE;
                end
            end
            default:
            begin
                tstate <= T_IDLE;
            end
        endcase
        // Wide acknowledge for the whole claimed transaction
        ack64_oe_o <= claimed;
        ack64_b_o <= ~(claimed & ~req64_s);
    end
end

// PIO master address phase, one 32-bit cycle
reg [1:0] pstate;
assign pio_busy_o = (pstate != P_IDLE);

always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        pstate <= P_IDLE;
        mst_frame_b_o <= 1'b1;
        mst_oe_o <= 1'b0;
        mst_ad_o <= 32'h0000_0000;
        mst_cbe_o <= 4'h0;
        pio_done_o <= 1'b0;
        pio_err_o <= 1'b0;
    end
    else
    begin
        pio_done_o <= 1'b0;
        pio_err_o <= 1'b0;
        case (pstate)
            P_IDLE:
            begin
                if (pio_req_i)
                begin
                    if (pio_addr_i >= `PIO_MEM_LIMIT)
                    begin
                        pio_err_o <= 1'b1;
                    end
                    else
                    begin
                        mst_ad_o <= pio_addr_i;
                        mst_cbe_o <= pio_write_i ? `CMD_MEM_WRITE : `CMD_MEM_READ;
                        pstate <= P_WAIT;
                    end
                end
            end
            P_WAIT:
            begin
                if (pci_rise)
                begin
                    mst_oe_o <= 1'b1;
                    mst_frame_b_o <= 1'b0;
                    pstate <= P_ADDR;
                end
            end
            P_ADDR:
            begin
                if (pci_rise)
                begin
                    mst_oe_o <= 1'b0;
                    mst_frame_b_o <= 1'b1;
                    pio_done_o <= 1'b1;
                    pstate <= P_IDLE;
                end
            end
            default:
            begin
                pstate <= P_IDLE;
            end
        endcase
    end
end

endmodule // pcix_bridge_bus

//--- pcix_bridge_bus_monitor.sv
// Port-level assertions for the bus-side bridge logic
`timescale 1ns/100ps
`include "pcix_bridge_defs.vh"
module pcix_bridge_bus_monitor #(
    parameter LOCAL_NODE = 12'h000
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire [7:0] int_b_i,
    input wire [1:0] slot_present_i,
    input wire pio_req_i,
    input wire [31:0] pio_addr_i,
    input wire map_req_i,
    input wire [1:0] gnt_b_o,
    input wire [7:0] bridge_irq_o,
    input wire bus_pcix_o,
    input wire [1:0] bus_speed_o,
    input wire [1:0] slot_enable_o,
    input wire ack64_b_o,
    input wire ack64_oe_o,
    input wire mst_frame_b_o,
    input wire mst_oe_o,
    input wire [3:0] mst_cbe_o,
    input wire pio_busy_o,
    input wire pio_err_o,
    input wire map_ack_o,
    input wire map_fail_o,
    input wire dma_valid_o,
    input wire dma_miss_o,
    input wire [49:0] dma_phys_o,
    input wire dma_remote_o
);
    wire pio_take = pio_req_i && !pio_busy_o;
    // Two-slot build: inputs 2, 3, 6 and 7 never see a slot
    wire [7:0] irq_exp = {2'h0, ~(int_b_i[5] & int_b_i[7]), ~(int_b_i[1] & int_b_i[3]),
        2'h0, ~(int_b_i[4] & int_b_i[6]), ~(int_b_i[0] & int_b_i[2])};
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    a_irq_route: assert property ($stable(int_b_i)[*4] |-> bridge_irq_o == irq_exp)
        else $error("bridge interrupt routing wrong");
    a_enable_present: assert property ($stable(slot_present_i)[*5] |-> slot_enable_o == slot_present_i)
        else $error("slot enable does not follow presence");
    a_top_speed: assert property (bus_speed_o == `SPEED_133 |-> bus_pcix_o && slot_enable_o != 2'h3)
        else $error("top speed with two slots enabled");
    a_conv_slow: assert property (!bus_pcix_o |-> bus_speed_o <= `SPEED_66)
        else $error("conventional mode above 66");
    a_pio_limit: assert property (pio_take && pio_addr_i >= `PIO_MEM_LIMIT |=> pio_err_o)
        else $error("window address not refused");
    a_pio_inside: assert property (pio_take && pio_addr_i < `PIO_MEM_LIMIT |=> !pio_err_o && pio_busy_o)
        else $error("legal window address refused");
    a_mst_phase: assert property (mst_oe_o |-> !mst_frame_b_o && (mst_cbe_o == `CMD_MEM_READ
        || mst_cbe_o == `CMD_MEM_WRITE))
        else $error("master phase not a single memory command");
    a_map_answer: assert property (map_req_i |=> map_ack_o != map_fail_o)
        else $error("map request not answered once");
    a_map_idle: assert property (!map_req_i |=> !map_ack_o && !map_fail_o)
        else $error("map answer without request");
    a_gnt_single: assert property (gnt_b_o != 2'h0)
        else $error("two grants at once");
    a_dma_remote: assert property (dma_valid_o |-> !dma_miss_o
        && dma_remote_o == (dma_phys_o[49:38] != LOCAL_NODE))
        else $error("remote flag wrong");
    a_ack_claim: assert property (!ack64_b_o |-> ack64_oe_o)
        else $error("wide acknowledge while not driving");
    c_map_fail: cover property (map_fail_o);
    c_dma_remote: cover property (dma_valid_o && dma_remote_o);
    c_pio_err: cover property (pio_err_o);
    c_mst_phase: cover property (mst_oe_o);
endmodule // pcix_bridge_bus_monitor

bind pcix_bridge_bus pcix_bridge_bus_monitor #(.LOCAL_NODE(LOCAL_NODE)) u_mon (.*);

//--- pcix_bridge_defs.vh
// Constants shared by the bus-side bridge logic
`ifndef PCIX_BRIDGE_DEFS_VH
`define PCIX_BRIDGE_DEFS_VH

`define SPEED_33 2'h0
`define SPEED_66 2'h1
`define SPEED_100 2'h2
`define SPEED_133 2'h3

`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_DUAL_ADDR 4'hd

`define PIO_MEM_LIMIT 32'h0400_0000
`define DMA32_WIN_SEL 2'h1
`define DMA32_PAGE_BITS 22
`define PHYS_WIDTH 50
`define PHYS_PAGE_WIDTH 28
`define NODE_LSB 38
`define CTL_PREFETCH_BIT 63
`define CTL_SWAP_BIT 62

`endif

//--- pcix_card_model.sv
// Bus-master card model that issues DMA address phases
`timescale 1ns/100ps
`include "pcix_bridge_defs.vh"
module pcix_card_model (
    input wire pci_clk_i,
    output reg frame_b_o,
    output reg req64_b_o,
    output reg [3:0] cbe_o,
    output reg [63:0] ad_o
);
    initial
    begin
        frame_b_o = 1'b1;
        req64_b_o = 1'b1;
        cbe_o = 4'h0;
        ad_o = 64'h0;
    end
    // Released lines show the inverse; one bus clock later AD shows the old address again while C/BE stays inverted
    task cycle(input [3:0] cmd, input [63:0] addr);
        begin
            @(posedge pci_clk_i);
            #2;
            frame_b_o = 1'b0;
            req64_b_o = 1'b0;
            ad_o = {32'h0, addr[31:0]};
            if (addr[63:32] != 32'h0)
            begin
                cbe_o = `CMD_DUAL_ADDR;
                @(posedge pci_clk_i);
                #2;
                ad_o = {32'h0, addr[63:32]};
            end
            cbe_o = cmd;
            @(posedge pci_clk_i);
            #2;
            frame_b_o = 1'b1;
            ad_o = ~ad_o;
            cbe_o = ~cbe_o;
            @(posedge pci_clk_i);
            #2;
            req64_b_o = 1'b1;
            ad_o = ~ad_o;
        end
    endtask
endmodule // pcix_card_model

//--- pcix_host_bridge_bus_side_tb_top.sv
// Self-checking bench for the bus-side bridge logic
`timescale 1ns/100ps
`include "pcix_bridge_defs.vh"
module pcix_host_bridge_bus_side_tb_top;
    reg clock_i = 1'b0, rst_b_i = 1'b0, pci_clk_i = 1'b0;
    reg lock_b_i = 1'b1, sbo_b_i = 1'b1, sdone_i = 1'b0;
    reg [1:0] req_b_i = 2'h3, slot_present_i = 2'h0, slot_pcix_i = 2'h0;
    reg [7:0] int_b_i = 8'hff;
    reg [3:0] slot_speed_i = 4'h0, map_free_index_i = 4'h0;
    reg pio_req_i = 1'b0, pio_write_i = 1'b0, map_req_i = 1'b0, map_free_i = 1'b0;
    reg [31:0] pio_addr_i = 32'h0;
    reg [27:0] map_page_i = 28'h0;
    reg [1:0] map_ctl_i = 2'h0;
    wire frame_b_i, req64_b_i, bus_pcix_o, ack64_b_o, ack64_oe_o, mst_frame_b_o, mst_oe_o;
    wire pio_busy_o, pio_done_o, pio_err_o, map_ack_o, map_fail_o, dma_valid_o, dma_miss_o;
    wire dma_remote_o, dma_prefetch_o, dma_swap_o;
    wire [3:0] cbe_i, mst_cbe_o, map_index_o;
    wire [63:0] ad_i;
    wire [1:0] gnt_b_o, bus_speed_o, slot_enable_o;
    wire [7:0] bridge_irq_o;
    wire [31:0] mst_ad_o;
    wire [49:0] dma_phys_o;
    integer errors = 0, compares = 0;
    pcix_card_model card (.pci_clk_i, .frame_b_o(frame_b_i), .req64_b_o(req64_b_i),
        .cbe_o(cbe_i), .ad_o(ad_i));
    pcix_bridge_bus u_dut (.*);
    initial
        forever #4 clock_i = ~clock_i;
    // Bus edges land 7 ns before a system edge
    initial
    begin
        #37;
        forever #80 pci_clk_i = ~pci_clk_i;
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clock_i);
            #1;
        end
    endtask
    task chk(input ok, input [8*28:1] msg);
        begin
            compares = compares + 1;
            if (ok !== 1'b1)
            begin
                errors = errors + 1;
                $display("[ERR] %0t %0s", $time, msg);
            end
        end
    endtask
    task close_out;
        begin
            $display("compares %0d errors %0d", compares, errors);
            if (errors == 0 && compares > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task t_speed;
        integer i;
        reg [10:0] v;
        begin
            for (i = 0; i < 5; i = i + 1)
            begin
                case (i)
                    0: v = {2'h1, 2'h1, 4'h3, 1'b1, `SPEED_133};
                    1: v = {2'h3, 2'h3, 4'hf, 1'b1, `SPEED_100};
                    2: v = {2'h3, 2'h3, 4'h6, 1'b1, `SPEED_66};
                    3: v = {2'h3, 2'h1, 4'h7, 1'b0, `SPEED_66};
                    default: v = {2'h0, 2'h0, 4'h0, 1'b0, `SPEED_33};
                endcase
                {slot_present_i, slot_pcix_i, slot_speed_i} = v[10:3];
                tick(6);
                chk(bus_pcix_o === v[2] && bus_speed_o === v[1:0], "bus mode");
                chk(slot_enable_o === v[10:9], "slot enable");
            end
            $display("speed test done");
        end
    endtask
    task t_irq;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1)
            begin
                int_b_i = ~(8'h1 << k);
                tick(5);
                chk(bridge_irq_o === (8'h1 << (k / 4 + (k % 2) * 4)), "irq route");
            end
            int_b_i = 8'hfc;
            tick(5);
            chk(bridge_irq_o === 8'h11, "two distinct irqs");
            int_b_i = 8'hff;
            tick(5);
            $display("interrupt test done");
        end
    endtask
    task map_req(input [27:0] page, input [1:0] ctl);
        begin
            map_page_i = page;
            map_ctl_i = ctl;
            map_req_i = 1'b1;
            tick(1);
            map_req_i = 1'b0;
        end
    endtask
    task t_map;
        integer i;
        begin
            for (i = 0; i < 16; i = i + 1)
            begin
                map_req(28'h100 + i[3:0], 2'h0);
                chk(map_ack_o === 1'b1 && map_index_o === i[3:0], "map alloc");
                tick(1);
            end
            map_req(28'h0, 2'h0);
            chk(map_fail_o === 1'b1 && map_ack_o === 1'b0, "pool full");
            tick(1);
            map_free_index_i = 4'h5;
            map_free_i = 1'b1;
            tick(1);
            map_free_i = 1'b0;
            tick(1);
            map_req(28'habc, 2'h2);
            chk(map_ack_o === 1'b1 && map_index_o === 4'h5, "freed entry reused");
            tick(1);
            $display("map test done");
        end
    endtask
    task dma(input [3:0] cmd, input [63:0] addr, input hit, input [49:0] phys, input [1:0] ctl);
        integer n;
        begin
            n = 0;
            fork
                card.cycle(cmd, addr);
                begin
                    while (!(dma_valid_o | dma_miss_o) && n < 400)
                    begin
                        tick(1);
                        n = n + 1;
                    end
                    chk(dma_valid_o === hit && dma_miss_o === !hit, "dma result");
                    if (hit)
                        chk(dma_phys_o === phys && {dma_prefetch_o, dma_swap_o} === ctl
                            && dma_remote_o === (phys[49:38] != 12'h0), "dma target");
                end
            join
        end
    endtask
    task t_dma;
        begin
            dma(`CMD_MEM_READ, 64'h4140_1234, 1'b1, {28'habc, 22'h001234}, 2'h2);
            dma(`CMD_MEM_WRITE, 64'h4500_0010, 1'b0, 50'h0, 2'h0);
            lock_b_i = 1'b0;
            sbo_b_i = 1'b0;
            sdone_i = 1'b1;
            dma(`CMD_MEM_READ, 64'h8000_1234_5678_9abc, 1'b1, 50'h1234_5678_9abc, 2'h2);
            dma(`CMD_MEM_WRITE, 64'h4000_0000_0000_1000, 1'b1, 50'h1000, 2'h1);
            lock_b_i = 1'b1;
            sbo_b_i = 1'b1;
            sdone_i = 1'b0;
            $display("dma test done");
        end
    endtask
    task t_pio;
        integer i, n;
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                pio_write_i = i[0];
                pio_addr_i = 32'h03ff_fffc;
                pio_req_i = 1'b1;
                tick(1);
                pio_req_i = 1'b0;
                n = 0;
                while (mst_oe_o !== 1'b1 && n < 200)
                begin
                    tick(1);
                    n = n + 1;
                end
                chk(mst_frame_b_o === 1'b0 && mst_ad_o === 32'h03ff_fffc
                    && mst_cbe_o === (i ? `CMD_MEM_WRITE : `CMD_MEM_READ), "pio address phase");
                while (pio_done_o !== 1'b1 && n < 200)
                begin
                    tick(1);
                    n = n + 1;
                end
                chk(mst_oe_o === 1'b0 && pio_done_o === 1'b1, "pio done");
                tick(1);
            end
            pio_addr_i = `PIO_MEM_LIMIT;
            pio_req_i = 1'b1;
            tick(1);
            pio_req_i = 1'b0;
            chk(pio_err_o === 1'b1 && mst_oe_o === 1'b0, "pio limit");
            tick(2);
            $display("pio test done");
        end
    endtask
    task t_arb;
        begin
            req_b_i = 2'b00;
            tick(60);
            chk(gnt_b_o === 2'b10, "real-time first");
            req_b_i = 2'b01;
            tick(60);
            chk(gnt_b_o === 2'b01, "low group served");
            req_b_i = 2'b11;
            tick(60);
            chk(gnt_b_o === 2'b11, "no grant when idle");
            $display("arbiter test done");
        end
    endtask
    // Tests need about 5.3 us
    initial
    begin
        #400000;
        errors = errors + 1;
        $display("[ERR] %0t watchdog expired", $time);
        close_out;
    end
    initial
    begin
        tick(10);
        rst_b_i = 1'b1;
        tick(2);
        t_speed;
        t_irq;
        t_map;
        t_dma;
        t_pio;
        t_arb;
        close_out;
    end
endmodule // pcix_host_bridge_bus_side_tb_top

//--- rr_group.v
// Round-robin grant picker for one priority group
`timescale 1ns/100ps
module rr_group #(
    parameter N = 2,
    parameter PW = 1
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire [N-1:0] req_i,
    input wire advance_i,
    output reg [N-1:0] grant_o,
    output wire any_o
);

reg [PW-1:0] ptr;
reg [PW-1:0] win;
reg found;
integer k;
integer idx;

assign any_o = |req_i;

always @*
begin
    grant_o = {N{1'b0}};
    win = ptr;
    found = 1'b0;
    idx = 0;
    for (k = 0; k < N; k = k + 1)
    begin
        idx = (ptr + k) % N;
        if (!found && req_i[idx])
        begin
            found = 1'b1;
            win = idx[PW-1:0];
        end
    end
    if (found)
    begin
        grant_o[win] = 1'b1;
    end
end

// Step past the member just served so nobody starves
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        ptr <= {PW{1'b0}};
    end
    else if (advance_i && found)
    begin
        ptr <= (win == N - 1) ? {PW{1'b0}} : win + 1'b1;
    end
end

endmodule // rr_group
